// *** core/apm_pkg.sv ***
// constants and types for the activity power manager
// Function
// - three inactivity timers: doze, standby, suspend
// - timer expiry raises management interrupt
// - activity while powered down raises interrupt
// - three deeper states chosen by longer idleness
// - house-keeping bursts absorbed in doze and standby only
// - peripheral timer flags peripheral inactivity
// - suspend output throttled in on, doze and standby; held low in suspend
// - power plane control outputs
// - internal clocks stop in suspend once the processor has drained
package apm_pkg;
  localparam int unsigned TIMER_W     = 16;
  localparam int unsigned PLANES      = 4;
  localparam logic [15:0] DOZE_DEF    = 16'h0100;
  localparam logic [15:0] STBY_DEF    = 16'h1000;
  localparam logic [15:0] SUSPEND_THROTTLE_OUT_DEF    = 16'h8000;
  localparam logic [15:0] HK_DEF      = 16'h0020;
  localparam logic [15:0] PERIPH_DEF  = 16'h4000;
  localparam logic [3:0]  PLANE_RST   = 4'hF;
  localparam logic [3:0]  THROT_RST   = 4'h0;
  typedef enum logic [1:0] {
    APM_ON,
    APM_DOZE,
    APM_STBY,
    APM_SUSPEND_THROTTLE_OUT
  } apm_state_t;
endpackage

// *** core/apm_idle_timer.sv ***
// reloadable down-counting inactivity timer
`timescale 1ns/1ps
`default_nettype none
module apm_idle_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         run,
  input  wire logic         reload,
  input  wire logic [W-1:0] period,
  output logic              expired
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         exp_r;
  logic         exp_nxt;
  logic         load_r;
  logic         load_nxt;

  // activity wins over counting; expiry is a one-cycle pulse
  // first enabled cycle after reset takes the period, so the first expiry
  // comes after a full programmed interval rather than the all-ones count
  always_comb begin
    cnt_nxt  = cnt_r;
    exp_nxt  = 1'b0;
    load_nxt = 1'b0;
    if (reload || !run || load_r) begin
      cnt_nxt = period;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      exp_nxt = (cnt_r == W'(1));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '1;
      exp_r  <= 1'b0;
      load_r <= 1'b1;
    end else if (ce) begin
      cnt_r  <= cnt_nxt;
      exp_r  <= exp_nxt;
      load_r <= load_nxt;
    end
  end

  assign expired = exp_r;
endmodule
`default_nettype wire

// *** core/apm_power_manager.sv ***
// activity power manager: idle timers, power states, interrupt, throttle
`timescale 1ns/1ps
`default_nettype none
module apm_power_manager #(
  parameter int unsigned W = apm_pkg::TIMER_W,
  parameter int unsigned NP = apm_pkg::PLANES
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          ce,
  input  wire logic          sys_activity,
  input  wire logic          hk_activity,
  input  wire logic          periph_activity,
  input  wire logic [W-1:0]  doze_period,
  input  wire logic [W-1:0]  stby_period,
  input  wire logic [W-1:0]  suspend_throttle_out_period,
  input  wire logic [W-1:0]  hk_period,
  input  wire logic [W-1:0]  periph_period,
  input  wire logic          expiry_irq_en,
  input  wire logic          wake_irq_en,
  input  wire logic          goto_on,
  input  wire logic          goto_doze,
  input  wire logic          goto_stby,
  input  wire logic          goto_suspend_throttle_out,
  input  wire logic          auto_step,
  input  wire logic [3:0]    throttle_duty,
  input  wire logic [NP-1:0] plane_off_req,
  input  wire logic          cpu_drained,
  input  wire logic          irq_ack,
  output logic               system_mgmt_interrupt,
  output logic [1:0]         irq_cause,
  output logic               suspend_throttle_out,
  output logic [NP-1:0]      plane_power_en,
  output logic               clock_run,
  output logic               periph_idle,
  output logic [1:0]         power_state
);
  initial begin
    if (W < 2 || NP < 1) $error("apm: bad parameters");
  end

  // reset release through two flops
  logic rs1_r;
  logic rs2_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  wire logic rst_n = rs2_r;

  // activity pins come from outside: two-flop synchronisers
  logic [2:0] act_s1_r;
  logic [2:0] act_s2_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_s1_r <= 3'h0;
      act_s2_r <= 3'h0;
    end else if (ce) begin
      act_s1_r <= {periph_activity, hk_activity, sys_activity};
      act_s2_r <= act_s1_r;
    end
  end
  wire logic sys_act = act_s2_r[0];
  wire logic hk_act  = act_s2_r[1];
  wire logic per_act = act_s2_r[2];

  apm_pkg::apm_state_t st_r;
  apm_pkg::apm_state_t st_nxt;
  logic                irq_r;
  logic                irq_nxt;
  logic [1:0]          cause_r;
  logic [1:0]          cause_nxt;
  logic                hk_busy_r;
  logic                hk_busy_nxt;
  logic                per_idle_r;
  logic                per_idle_nxt;
  logic                doze_exp;
  logic                stby_exp;
  logic                suspend_throttle_out_exp;
  logic                hk_exp;
  logic                per_exp;

  // house-keeping bursts do not count as system activity while dozing/standby
  wire logic powered_down = (st_r != apm_pkg::APM_ON);
  wire logic hk_absorbed  = hk_act && (st_r == apm_pkg::APM_DOZE
                                       || st_r == apm_pkg::APM_STBY);
  wire logic eff_act = sys_act || (hk_act && !hk_absorbed);

  // three idle timers, each reloaded by system activity
  apm_idle_timer #(.W(W)) u_doze (.clock(clock), .rst_n(rst_n), .ce(ce),
    .run(1'b1), .reload(eff_act), .period(doze_period), .expired(doze_exp));
  apm_idle_timer #(.W(W)) u_stby (.clock(clock), .rst_n(rst_n), .ce(ce),
    .run(1'b1), .reload(eff_act), .period(stby_period), .expired(stby_exp));
  apm_idle_timer #(.W(W)) u_suspend_throttle_out (.clock(clock), .rst_n(rst_n), .ce(ce),
    .run(1'b1), .reload(eff_act), .period(suspend_throttle_out_period), .expired(suspend_throttle_out_exp));
  // house-keeping window: counts down once an absorbed burst ends, until it expires
  apm_idle_timer #(.W(W)) u_hk (.clock(clock), .rst_n(rst_n), .ce(ce),
    .run(hk_busy_r), .reload(hk_absorbed), .period(hk_period),
    .expired(hk_exp));
  apm_idle_timer #(.W(W)) u_per (.clock(clock), .rst_n(rst_n), .ce(ce),
    .run(1'b1), .reload(per_act), .period(periph_period),
    .expired(per_exp));

  // power state, interrupt and side timers
  always_comb begin
    st_nxt       = st_r;
    irq_nxt      = irq_r;
    cause_nxt    = cause_r;
    hk_busy_nxt  = hk_busy_r;
    per_idle_nxt = per_idle_r;
    if (hk_absorbed) hk_busy_nxt = 1'b1;
    else if (hk_exp) hk_busy_nxt = 1'b0;
    if (per_act) per_idle_nxt = 1'b0;
    else if (per_exp) per_idle_nxt = 1'b1;
    if (irq_ack) irq_nxt = 1'b0;
    // software moves; optional hardware stepping deeper
    if (goto_on) st_nxt = apm_pkg::APM_ON;
    else if (goto_suspend_throttle_out) st_nxt = apm_pkg::APM_SUSPEND_THROTTLE_OUT;
    else if (goto_stby) st_nxt = apm_pkg::APM_STBY;
    else if (goto_doze) st_nxt = apm_pkg::APM_DOZE;
    else if (auto_step) begin
      unique case (st_r)
        apm_pkg::APM_ON:   if (doze_exp) st_nxt = apm_pkg::APM_DOZE;
        apm_pkg::APM_DOZE: if (stby_exp) st_nxt = apm_pkg::APM_STBY;
        apm_pkg::APM_STBY: if (suspend_throttle_out_exp) st_nxt = apm_pkg::APM_SUSPEND_THROTTLE_OUT;
        apm_pkg::APM_SUSPEND_THROTTLE_OUT: ;
      endcase
    end
    // set wins over acknowledge
    if (expiry_irq_en && (doze_exp || stby_exp || suspend_throttle_out_exp)) begin
      irq_nxt   = 1'b1;
      cause_nxt = 2'h1;
    end
    if (wake_irq_en && powered_down && eff_act) begin
      irq_nxt   = 1'b1;
      cause_nxt = 2'h2;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= apm_pkg::APM_ON;
      irq_r      <= 1'b0;
      cause_r    <= 2'h0;
      hk_busy_r  <= 1'b0;
      per_idle_r <= 1'b0;
    end else if (ce) begin
      st_r       <= st_nxt;
      irq_r      <= irq_nxt;
      cause_r    <= cause_nxt;
      hk_busy_r  <= hk_busy_nxt;
      per_idle_r <= per_idle_nxt;
    end
  end

  // throttle: duty out of 16 slots low on the suspend output
  logic [3:0]    ph_r;
  logic [3:0]    ph_nxt;
  logic          thr_r;
  logic          thr_nxt;
  logic          clk_run_r;
  logic          clk_run_nxt;
  logic [NP-1:0] plane_r;
  logic [NP-1:0] plane_nxt;
  always_comb begin
    ph_nxt      = ph_r + 4'h1;
    thr_nxt     = (ph_r >= throttle_duty);
    // clocks stop only once the processor has drained
    clk_run_nxt = !(st_r == apm_pkg::APM_SUSPEND_THROTTLE_OUT && cpu_drained);
    if (st_r == apm_pkg::APM_SUSPEND_THROTTLE_OUT) thr_nxt = 1'b0;
    plane_nxt   = ~plane_off_req;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_r      <= 4'h0;
      thr_r     <= 1'b1;
      clk_run_r <= 1'b1;
      plane_r   <= {NP{1'b1}};
    end else if (ce) begin
      ph_r      <= ph_nxt;
      thr_r     <= thr_nxt;
      clk_run_r <= clk_run_nxt;
      plane_r   <= plane_nxt;
    end
  end

  assign system_mgmt_interrupt = irq_r;
  assign irq_cause             = cause_r;
  assign suspend_throttle_out  = thr_r;
  assign plane_power_en        = plane_r;
  assign clock_run             = clk_run_r;
  assign periph_idle           = per_idle_r;
  assign power_state           = st_r;

  a_wake_irq: assert property (@(posedge clock) disable iff (!rst_n)
    ce && wake_irq_en && powered_down && eff_act |=> irq_r)
    else $error("wake activity gave no interrupt");
  a_expiry_irq: assert property (@(posedge clock) disable iff (!rst_n)
    ce && expiry_irq_en && doze_exp |=> irq_r && cause_r != 2'h0)
    else $error("expiry gave no interrupt");
  a_clock_stop: assert property (@(posedge clock) disable iff (!rst_n)
    ce && st_r == apm_pkg::APM_SUSPEND_THROTTLE_OUT && cpu_drained |=> !clk_run_r)
    else $error("clocks ran in suspend");
  a_clock_wait: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !cpu_drained |=> clk_run_r)
    else $error("clocks stopped before drain");
  a_state_step: assert property (@(posedge clock) disable iff (!rst_n)
    ce && auto_step && !goto_on && !goto_doze && !goto_stby && !goto_suspend_throttle_out
      && st_r == apm_pkg::APM_ON && doze_exp |=> st_r == apm_pkg::APM_DOZE)
    else $error("no step to doze");
  a_hk_absorb: assert property (@(posedge clock) disable iff (!rst_n)
    ce && hk_absorbed && !sys_act
      && !(expiry_irq_en && (doze_exp || stby_exp || suspend_throttle_out_exp))
      |=> cause_r != 2'h2 || $past(cause_r) == 2'h2)
    else $error("house-keeping woke system");
  a_per_idle: assert property (@(posedge clock) disable iff (!rst_n)
    ce && per_exp && !per_act |=> per_idle_r)
    else $error("peripheral idle missed");
  a_plane_ctl: assert property (@(posedge clock) disable iff (!rst_n)
    ce |=> plane_r == ~$past(plane_off_req))
    else $error("plane control wrong");
  a_throttle: assert property (@(posedge clock) disable iff (!rst_n)
    ce && st_r == apm_pkg::APM_ON && throttle_duty == 4'hF && ph_r == 4'h0 |=> !thr_r)
    else $error("throttle inactive in on state");
endmodule
`default_nettype wire

// *** sim/apm_cpu_model.sv ***
// processor core model: drains pending work before suspend stops it
`timescale 1ns/1ps
`default_nettype none
module apm_cpu_model #(
  parameter int unsigned DRAIN = 3
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [1:0] power_state,
  output logic            cpu_drained
);
  logic [3:0] cnt_r;
  // finish current and decoded work first, slow on purpose
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      cpu_drained <= 1'b0;
    end else if (power_state != 2'h3) begin
      cnt_r <= 4'h0;
      cpu_drained <= 1'b0;
    end else if (cnt_r < 4'(DRAIN)) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      cpu_drained <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the activity power manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin total_checks++; if ((g)!==(e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
`define WT(c,n) for (int k = 0; k < (n) && !(c); k++) @(negedge clock);
module testbench;
  logic clock = 0, nrst = 0, sa = 0, ha = 0, pa = 0, xen = 0, wen = 0;
  logic on = 0, dz = 0, sb = 0, sp = 0, step = 0, ack = 0, drained;
  logic ce = 1, hold;
  logic [3:0] duty = 4'h0, poff = 4'h0, pen;
  logic irq, thr, crun, pidle;
  logic [1:0] cause, st;
  int miscompares = 0, total_checks = 0, cyc = 0, lows;
  apm_power_manager i_apm_power_manager (.clock(clock), .nrst(nrst), .ce(ce),
    .sys_activity(sa), .hk_activity(ha), .periph_activity(pa),
    .doze_period(16'h0008), .stby_period(16'h0010), .suspend_throttle_out_period(16'h0020),
    .hk_period(16'h0004), .periph_period(16'h0014), .expiry_irq_en(xen),
    .wake_irq_en(wen), .goto_on(on), .goto_doze(dz), .goto_stby(sb),
    .goto_suspend_throttle_out(sp), .auto_step(step), .throttle_duty(duty),
    .plane_off_req(poff), .cpu_drained(drained), .irq_ack(ack),
    .system_mgmt_interrupt(irq), .irq_cause(cause), .suspend_throttle_out(thr),
    .plane_power_en(pen), .clock_run(crun), .periph_idle(pidle), .power_state(st));
  apm_cpu_model i_apm_cpu_model (.clock(clock), .nrst(nrst), .power_state(st),
    .cpu_drained(drained));
  // clock at 250 MHz
  initial begin
    forever #2 clock = ~clock;
  end
  // hang guard, generous for the short periods used
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_planes();
    poff = 4'h5;
    repeat (3) @(negedge clock);
    `CHK("planes", 4'hA, pen)
    poff = 4'h0;
    repeat (3) @(negedge clock);
    `CHK("planes", 4'hF, pen)
    $display("planes done");
  endtask
  task automatic t_throttle();
    duty = 4'h4;
    repeat (20) @(negedge clock);
    lows = 0;
    repeat (16) begin
      @(negedge clock);
      lows += int'(thr === 1'b0);
    end
    `CHK("throttle lows", 4, lows)
    // clock enable low must freeze the free-running throttle phase
    ce = 1'b0;
    hold = thr;
    lows = 0;
    repeat (20) begin
      @(negedge clock);
      lows += int'(thr !== hold);
    end
    `CHK("frozen throttle", 0, lows)
    ce = 1'b1;
    duty = 4'hF;
    repeat (20) @(negedge clock);
    lows = 0;
    repeat (16) begin
      @(negedge clock);
      lows += int'(thr === 1'b0);
    end
    `CHK("throttle full", 15, lows)
    duty = 4'h0;
    $display("throttle done");
  endtask
  task automatic t_reload();
    step = 1;
    repeat (15) begin
      sa = ~sa;
      repeat (4) @(negedge clock);
    end
    `CHK("state busy", 2'h0, st)
    // activity stays high so the timers stay loaded until t_step
    $display("reload done");
  endtask
  task automatic t_periph();
    pa = 1;
    repeat (5) @(negedge clock);
    pa = 0;
    `WT(pidle === 1'b1, 60)
    `CHK("periph idle", 1'b1, pidle)
    pa = 1;
    `WT(pidle === 1'b0, 8)
    `CHK("periph busy", 1'b0, pidle)
    pa = 0;
    $display("periph done");
  endtask
  task automatic t_step();
    xen = 1;
    wen = 1;
    sa = 0;
    // sync takes two edges, then the doze period must run out in full
    repeat (9) @(negedge clock);
    `CHK("no early doze", 2'h0, st)
    `WT(st === 2'h1, 60)
    `CHK("doze", 2'h1, st)
    repeat (2) @(negedge clock);
    `CHK("expiry irq", 1'b1, irq)
    `CHK("cause", 2'h1, cause)
    ha = 1;
    repeat (3) @(negedge clock);
    ha = 0;
    repeat (4) @(negedge clock);
    `CHK("hk no wake", 2'h1, cause)
    ack = 1;
    @(negedge clock);
    ack = 0;
    `WT(st === 2'h2, 120)
    `CHK("standby", 2'h2, st)
    `WT(st === 2'h3, 200)
    `CHK("suspend", 2'h3, st)
    `WT(crun === 1'b0, 40)
    `CHK("clock stop", 1'b0, crun)
    `CHK("throttle suspend_throttle_out", 1'b0, thr)
    $display("step done");
  endtask
  task automatic t_wake();
    ack = 1;
    @(negedge clock);
    ack = 0;
    wen = 1;
    sa = 1;
    `WT(cause === 2'h2, 10)
    `CHK("wake irq", 1'b1, irq)
    `CHK("wake cause", 2'h2, cause)
    step = 0;
    sa = 0;
    on = 1;
    @(negedge clock);
    on = 0;
    `WT(crun === 1'b1 && st === 2'h0, 8)
    `CHK("back on", 2'h0, st)
    `CHK("clock run", 1'b1, crun)
    $display("wake done");
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge clock);
    `CHK("rst irq", 1'b0, irq)
    `CHK("rst planes", 4'hF, pen)
    `CHK("rst state", 2'h0, st)
    nrst = 1;
    repeat (4) @(negedge clock);
    t_planes();
    t_throttle();
    t_reload();
    t_periph();
    t_step();
    t_wake();
    test_done();
  end
endmodule
`default_nettype wire
